// *** design/spi_eeprom_cmd_protect.sv ***
`timescale 1ns/1ps
`include "spi_guard_defs.svh"
// Functional notes
// (R1) Slave only; master makes every SCK edge
// (R2) MSB first; frames start on select falling
// (R3) First byte captured as eight-bit opcode
// (R4) Bad opcode: ignore rest, SO floats
// (R5) Deselected: SI ignored, SO floats
// (R6) Hold pauses transfer, sequence state kept
// (R7) While held: SO floats, SI ignored
// (R8) Decode set, clear, status-read opcodes
// (R9) Decode status-write, array read, write opcodes
// (R10) Latch clear at power-up; set first
// (R11) Clear-latch disables programming regardless of pin
// (R12) Status bit 0 shows write busy
// (R13) Status bit 1 shows write latch
// (R14) Guard bit 7, block bits 3 and 2
// (R15) Bits 6..4 zero; all ones when busy
// (R16) Small array quarter, half, full protection
// (R17) Large array quarter, half, full protection
// (R18) Protected locations never written
// (R19) Nonvolatile bits need latch, timed cycle
// (R20) Hardware guard: pin low and guard set
// (R21) Hardware guard blocks status, protected writes
// (R22) Pin falling in frame aborts status write; code aborts only while the guard bit is set
// (R23) Guard bit cannot clear while pin low; a status write cycle started before the pin fell still clears it
// (R24) Busy: only status-read accepted
// (R25) Write cycle end clears the latch
// (R26) Sample on rising SCK, shift on falling
// (R27) SO driven only in read data phases
module spi_eeprom_cmd_protect
#(
    parameter int ADDR_BITS    = 15,
    parameter int WRITE_CYCLES = `WRITE_CYCLES
)
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 cs_n,
    input  wire logic                 sck,
    input  wire logic                 si,
    input  wire logic                 hold_n,
    input  wire logic                 wp_n,
    output logic                      so_o,
    output logic                      so_oe,
    output logic [ADDR_BITS-1:0]      arr_addr,
    output logic [7:0]                arr_wdata,
    output logic                      arr_wr,
    input  wire logic [7:0]           arr_rdata,
    output logic                      busy
);

    localparam int WC_W = $clog2(WRITE_CYCLES + 1);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic       sck_d3_q;
    logic       cs_d3_q;
    logic       wp_d3_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q  <= 5'h1c;
            sync2_q  <= 5'h1c;
            sck_d3_q <= 1'b0;
            cs_d3_q  <= 1'b1;
            wp_d3_q  <= 1'b1;
        end
        else
        begin
            sync1_q  <= {wp_n, hold_n, cs_n, si, sck};
            sync2_q  <= sync1_q;
            sck_d3_q <= sync2_q[0];
            cs_d3_q  <= sync2_q[2];
            wp_d3_q  <= sync2_q[4];
        end
    end

    wire sck_s  = sync2_q[0];
    wire si_s   = sync2_q[1];
    wire cs_s   = sync2_q[2];
    wire hold_s = sync2_q[3];
    wire wp_s   = sync2_q[4];

    // ----------------------------------------
    // Frame and edge decode
    // ----------------------------------------
    spi_guard_pkg::frame_state_t state_q;
    spi_guard_pkg::frame_state_t state_d;
    spi_guard_pkg::wcycle_t      kind_q;

    logic [2:0]           bit_cnt_q;
    logic [7:0]           shift_q;
    logic [2:0]           op_q;
    logic [15:0]          addr_q;
    logic                 addr_byte_q;
    logic                 latch_q;
    logic                 guard_q;
    logic [1:0]           bp_q;
    logic [7:0]           pend_q;
    logic                 swpend_q;
    logic                 wrote_q;
    logic                 busy_q;
    logic [WC_W-1:0]      wc_cnt_q;
    logic [7:0]           out_sr_q;
    logic                 started_q;

    wire active    = ~cs_s & hold_s;                          // [R5] [R6] [R7]
    wire rise      = sck_s & ~sck_d3_q & active;              // [R1] [R26]
    wire fall      = ~sck_s & sck_d3_q & active;              // [R26]
    wire cs_fall   = cs_d3_q & ~cs_s;                         // [R2]
    wire cs_rise   = ~cs_d3_q & cs_s;
    wire wp_fall   = wp_d3_q & ~wp_s;
    wire byte_done = rise & (bit_cnt_q == 3'h7);
    wire [7:0] next_byte = {shift_q[6:0], si_s};              // [R2]

    // Opcode decode on the completed first byte
    wire op_ok      = next_byte[7:4] == `OP_HI_NIBBLE;        // [R3]
    wire [2:0] op_c = next_byte[2:0];
    wire is_set     = op_ok & (op_c == `OP_SET_LATCH);        // [R8]
    wire is_clear   = op_ok & (op_c == `OP_CLEAR_LATCH);      // [R8]
    wire is_sread   = op_ok & (op_c == `OP_STATUS_READ);      // [R8]
    wire is_swrite  = op_ok & (op_c == `OP_STATUS_WRITE);     // [R9]
    wire is_aread   = op_ok & (op_c == `OP_ARRAY_READ);       // [R9]
    wire is_awrite  = op_ok & (op_c == `OP_ARRAY_WRITE);      // [R9]
    wire op_valid   = is_set | is_clear | is_sread | is_swrite | is_aread | is_awrite;
    wire op_done    = byte_done & (state_q == spi_guard_pkg::ST_OPCODE);
    wire accepted   = op_valid & (~busy_q | is_sread);        // [R24]

    // ----------------------------------------
    // Protection decode
    // ----------------------------------------
    wire [ADDR_BITS-1:0] cur_addr = addr_q[ADDR_BITS-1:0];
    wire top1    = cur_addr[ADDR_BITS-1];
    wire top2    = cur_addr[ADDR_BITS-2];
    wire blocked = (bp_q == `BP_ALL) |                        // [R16] [R17]
                   ((bp_q == `BP_HALF) & top1) |
                   ((bp_q == `BP_QUARTER) & top1 & top2);
    wire hw_prot = ~wp_s & guard_q;                           // [R20]
    wire wc_done = busy_q & (wc_cnt_q == '0);

    wire [7:0] status_byte = busy_q ? `ST_BUSY_VALUE :        // [R15]
                             {guard_q, 3'h0, bp_q, latch_q, 1'b0}; // [R12] [R13] [R14]
    wire       rd_phase    = (state_q == spi_guard_pkg::ST_SREAD) | (state_q == spi_guard_pkg::ST_RDATA);
    wire [7:0] rd_src      = (state_q == spi_guard_pkg::ST_SREAD) ? status_byte : arr_rdata;

    // ----------------------------------------
    // Frame state machine
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        if (cs_s)
            state_d = spi_guard_pkg::ST_IDLE;                 // [R5]
        else if (cs_fall)
            state_d = spi_guard_pkg::ST_OPCODE;               // [R2] [R3]
        else if (byte_done)
        begin
            case (state_q)
                spi_guard_pkg::ST_OPCODE:
                begin
                    if (!accepted)
                        state_d = spi_guard_pkg::ST_IGNORE;   // [R4] [R24]
                    else if (is_sread)
                        state_d = spi_guard_pkg::ST_SREAD;
                    else if (is_aread)
                        state_d = spi_guard_pkg::ST_ADDR;
                    else if (is_swrite & latch_q)
                        state_d = spi_guard_pkg::ST_SWDATA;   // [R10] [R19]
                    else if (is_awrite & latch_q)
                        state_d = spi_guard_pkg::ST_ADDR;     // [R10]
                    else
                        state_d = spi_guard_pkg::ST_IGNORE;
                end
                spi_guard_pkg::ST_ADDR:
                begin
                    if (addr_byte_q)
                        state_d = (op_q == `OP_ARRAY_READ) ? spi_guard_pkg::ST_RDATA : spi_guard_pkg::ST_WDATA;
                end
                spi_guard_pkg::ST_SWDATA:
                    state_d = spi_guard_pkg::ST_IGNORE;
                default:
                    state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_q <= spi_guard_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    // ----------------------------------------
    // Input shifting and addressing
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_q   <= 3'h0;
            shift_q     <= 8'h00;
            op_q        <= 3'h0;
            addr_q      <= 16'h0000;
            addr_byte_q <= 1'b0;
        end
        else if (cs_fall)
        begin
            bit_cnt_q   <= 3'h0;
            addr_byte_q <= 1'b0;
        end
        else if (rise && state_q != spi_guard_pkg::ST_IGNORE)   // [R4] [R7]
        begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= next_byte;                             // [R2] [R26]
            if (op_done)
                op_q <= op_c;
            if (byte_done && state_q == spi_guard_pkg::ST_ADDR)
            begin
                addr_q      <= {addr_q[7:0], next_byte};
                addr_byte_q <= ~addr_byte_q;
            end
            if (byte_done && state_q == spi_guard_pkg::ST_RDATA)
                addr_q <= addr_q + 16'h0001;
            if (byte_done && state_q == spi_guard_pkg::ST_WDATA)
                addr_q <= {addr_q[15:`PAGE_BITS], addr_q[`PAGE_BITS-1:0] + {{(`PAGE_BITS-1){1'b0}}, 1'b1}};
        end
    end

    // ----------------------------------------
    // Array write strobe
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            arr_addr  <= '0;
            arr_wdata <= 8'h00;
            arr_wr    <= 1'b0;
            wrote_q   <= 1'b0;
        end
        else
        begin
            arr_addr <= cur_addr;
            arr_wr   <= byte_done & (state_q == spi_guard_pkg::ST_WDATA) & ~blocked;   // [R18] [R21]
            if (byte_done && state_q == spi_guard_pkg::ST_WDATA)
                arr_wdata <= next_byte;
            if (cs_fall)
                wrote_q <= 1'b0;
            else if (byte_done && state_q == spi_guard_pkg::ST_WDATA && !blocked)
                wrote_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Write latch and status write capture
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            latch_q <= 1'b0;                                    // [R10]
        else if (wc_done)
            latch_q <= 1'b0;                                    // [R25]
        else if (op_done && accepted && is_clear)
            latch_q <= 1'b0;                                    // [R11]
        else if (op_done && accepted && is_set)
            latch_q <= 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q   <= 8'h00;
            swpend_q <= 1'b0;
        end
        else if (cs_fall || (wp_fall && !cs_s && guard_q))
            swpend_q <= 1'b0;                                   // [R20] [R22]
        else if (byte_done && state_q == spi_guard_pkg::ST_SWDATA)
        begin
            pend_q   <= next_byte;
            swpend_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Self-timed write cycle and nonvolatile bits
    // ----------------------------------------
    wire start_status = cs_rise & swpend_q & latch_q & ~hw_prot & ~busy_q;   // [R19] [R21] [R23]
    wire start_array  = cs_rise & wrote_q & latch_q & ~busy_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_q   <= 1'b0;
            wc_cnt_q <= '0;
            kind_q   <= spi_guard_pkg::WC_ARRAY;
        end
        else if (start_status || start_array)
        begin
            busy_q   <= 1'b1;
            wc_cnt_q <= WC_W'(WRITE_CYCLES - 1);
            kind_q   <= start_status ? spi_guard_pkg::WC_STATUS : spi_guard_pkg::WC_ARRAY;
        end
        else if (wc_done)
            busy_q <= 1'b0;
        else if (busy_q)
            wc_cnt_q <= wc_cnt_q - 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            guard_q <= `NV_RESET_GUARD;
            bp_q    <= `NV_RESET_BP;
        end
        else if (wc_done && kind_q == spi_guard_pkg::WC_STATUS)   // [R19]
        begin
            guard_q <= pend_q[`ST_GUARD_BIT];
            bp_q    <= {pend_q[`ST_BPHI_BIT], pend_q[`ST_BPLO_BIT]};
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_sr_q  <= 8'h00;
            so_o      <= 1'b0;
            started_q <= 1'b0;
        end
        else if (cs_fall)
            started_q <= 1'b0;
        else if (fall && rd_phase)                              // [R26]
        begin
            started_q <= 1'b1;
            if (bit_cnt_q == 3'h0)
            begin
                so_o     <= rd_src[7];                          // [R2]
                out_sr_q <= {rd_src[6:0], 1'b0};
            end
            else
            begin
                so_o     <= out_sr_q[7];
                out_sr_q <= {out_sr_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            so_oe <= 1'b0;
            busy  <= 1'b0;
        end
        else
        begin
            so_oe <= active & rd_phase & (started_q | (fall & (bit_cnt_q == 3'h0)));   // [R5] [R7] [R27]
            busy  <= busy_q;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence opcode_end_s;
        op_done;
    endsequence

    sequence cycle_over_s;
        busy_q ##1 !busy_q;
    endsequence

    deselect_float_a: assert property (@(posedge clk) disable iff (rst) // [R5]
        cs_s |=> !so_oe)
        else $error("SO driven while deselected");

    hold_float_a: assert property (@(posedge clk) disable iff (rst) // [R7]
        (!cs_s && !hold_s) |=> !so_oe)
        else $error("SO driven while held");

    bad_opcode_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        (opcode_end_s and (##0 !op_valid && !cs_fall)) |=> state_q == spi_guard_pkg::ST_IGNORE)
        else $error("Invalid opcode not ignored");

    busy_only_sread_a: assert property (@(posedge clk) disable iff (rst) // [R24]
        (op_done && busy_q && !is_sread && !wc_done) |=> state_q == spi_guard_pkg::ST_IGNORE && latch_q == $past(latch_q))
        else $error("Command accepted while busy");

    clear_latch_a: assert property (@(posedge clk) disable iff (rst) // [R11]
        (op_done && is_clear && !busy_q) |=> !latch_q)
        else $error("Clear latch did not clear");

    cycle_end_latch_a: assert property (@(posedge clk) disable iff (rst) // [R25]
        cycle_over_s |-> !latch_q)
        else $error("Latch still set after write cycle");

    protected_write_a: assert property (@(posedge clk) disable iff (rst) // [R18]
        arr_wr |-> !((bp_q == `BP_ALL) || ((bp_q == `BP_HALF) && arr_addr[ADDR_BITS-1]) ||
                     ((bp_q == `BP_QUARTER) && arr_addr[ADDR_BITS-1] && arr_addr[ADDR_BITS-2])))
        else $error("Write issued to protected location");

    hw_guard_block_a: assert property (@(posedge clk) disable iff (rst) // [R21]
        (cs_rise && hw_prot && !busy_q && !wrote_q) |=> !busy_q)
        else $error("Status write passed hardware guard");

    busy_status_a: assert property (@(posedge clk) disable iff (rst) // [R15]
        (fall && state_q == spi_guard_pkg::ST_SREAD && bit_cnt_q == 3'h0 && busy_q) |=> so_o && out_sr_q == 8'hfe)
        else $error("Status not all ones while busy");

    msb_first_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        (rise && state_q == spi_guard_pkg::ST_OPCODE && !cs_fall) |=> shift_q[0] == $past(si_s))
        else $error("Serial input not shifted in order");

    wp_abort_a: assert property (@(posedge clk) disable iff (rst) // [R22]
        (wp_fall && !cs_s && guard_q) |=> !swpend_q ##1 !(cs_rise && swpend_q))
        else $error("Status write not aborted by pin");

endmodule

// *** design/spi_guard_defs.svh ***
`ifndef SPI_GUARD_DEFS_SVH
`define SPI_GUARD_DEFS_SVH

// ----------------------------------------
// Opcode fields: upper nibble zero, bit 3 ignored
// ----------------------------------------
`define OP_HI_NIBBLE       4'h0
`define OP_SET_LATCH       3'h6
`define OP_CLEAR_LATCH     3'h4
`define OP_STATUS_READ     3'h5
`define OP_STATUS_WRITE    3'h1
`define OP_ARRAY_READ      3'h3
`define OP_ARRAY_WRITE     3'h2

// ----------------------------------------
// Status register layout and values
// ----------------------------------------
`define ST_GUARD_BIT       7
`define ST_BPHI_BIT        3
`define ST_BPLO_BIT        2
`define ST_LATCH_BIT       1
`define ST_BUSY_BIT        0
`define ST_BUSY_VALUE      8'hff
`define NV_RESET_GUARD     1'h0
`define NV_RESET_BP        2'h0

// ----------------------------------------
// Block protect codes and paging
// ----------------------------------------
`define BP_NONE            2'h0
`define BP_QUARTER         2'h1
`define BP_HALF            2'h2
`define BP_ALL             2'h3
`define PAGE_BITS          6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS      50
`define WRITE_TIME_NS      5000000
`define WRITE_CYCLES       (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** design/spi_guard_pkg.sv ***
package spi_guard_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR   = 3'b010,
        ST_WDATA  = 3'b011,
        ST_RDATA  = 3'b100,
        ST_SREAD  = 3'b101,
        ST_SWDATA = 3'b110,
        ST_IGNORE = 3'b111
    } frame_state_t;

    typedef enum logic [1:0]
    {
        WC_ARRAY  = 2'b00,
        WC_STATUS = 2'b01
    } wcycle_t;

endpackage

// *** tb/link_master.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Serial master model, clock idle low
// ----------------------------------------
module link_master
(
    input  wire logic clk,
    input  wire logic so_line,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    output logic      held
);
    initial
    begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
        held   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic frame_open();
        cs_n = 1'b0;
        tick(4);
    endtask

    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            si = tx[i];
            tick(4);
            sck = 1'b1;
            tick(2);
            rx[i] = so_line;
            tick(2);
            sck = 1'b0;
        end
    endtask

    task automatic frame_close();
        tick(4);
        cs_n = 1'b1;
        si   = ~si;
        tick(8);
    endtask

    // Hold while clock low, clock keeps toggling
    task automatic pause(input int n);
        tick(4);
        hold_n = 1'b0;
        tick(6);
        held = 1'b1;
        repeat (n)
        begin
            sck = 1'b1;
            si  = ~si;
            tick(4);
            sck = 1'b0;
            tick(4);
        end
        held   = 1'b0;
        hold_n = 1'b1;
        tick(4);
    endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int WCYC = 400;
    logic        clk;
    logic        rst;
    logic        wp_n;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic        hold_n;
    logic        held;
    logic        so_o;
    logic        so_oe;
    logic        arr_wr;
    logic        busy;
    logic        watch;
    logic        oe_seen;
    logic [14:0] arr_addr;
    logic [14:0] last_addr;
    logic [7:0]  arr_wdata;
    logic [7:0]  last_data;
    logic [7:0]  arr_rdata;
    logic [7:0]  v;
    logic [15:0] lo;
    wire         so_line;
    int          mismatches;
    int          num_checks;
    int          wr_count;

    assign so_line   = so_oe ? so_o : 1'bz;
    assign arr_rdata = arr_addr[7:0] ^ 8'h5a;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    spi_eeprom_cmd_protect #(.ADDR_BITS(15), .WRITE_CYCLES(WCYC)) u_spi_eeprom_cmd_protect
    (
        .clk       (clk),
        .rst       (rst),
        .cs_n      (cs_n),
        .sck       (sck),
        .si        (si),
        .hold_n    (hold_n),
        .wp_n      (wp_n),
        .so_o      (so_o),
        .so_oe     (so_oe),
        .arr_addr  (arr_addr),
        .arr_wdata (arr_wdata),
        .arr_wr    (arr_wr),
        .arr_rdata (arr_rdata),
        .busy      (busy)
    );

    link_master u_link_master
    (
        .clk     (clk),
        .so_line (so_line),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .hold_n  (hold_n),
        .held    (held)
    );

    always @(posedge clk)
    begin
        if (arr_wr === 1'b1)
        begin
            wr_count++;
            last_addr = arr_addr;
            last_data = arr_wdata;
        end
        if ((watch || held) && so_oe !== 1'b0)
            oe_seen = 1'b1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++)
            tick(1);
        if (busy !== 1'b0)
        begin
            mismatches++;
            $display("Error busy expected 0 seen %b", busy);
            results();
        end
    endtask

    task automatic frame(input logic [7:0] q[$], input bit fin, output logic [7:0] rx);
        u_link_master.frame_open();
        foreach (q[i])
            u_link_master.xbyte(q[i], rx);
        if (fin)
            u_link_master.frame_close();
    endtask

    task automatic cmd(input logic [7:0] op);
        frame({op}, 1, v);
    endtask

    task automatic rd_status(input logic [7:0] op, output logic [7:0] rx);
        frame({op, 8'h00}, 1, rx);
    endtask

    task automatic wr_status(input logic [7:0] op, input logic [7:0] d, input logic exp_busy);
        cmd(8'h06);
        frame({op, d}, 1, v);
        check("status write busy", {15'h0, exp_busy}, {15'h0, busy});
        wait_idle();
    endtask

    task automatic wr_array(input logic [15:0] addr, input logic [7:0] d, input bit lat, input bit exp);
        int n;
        n = wr_count;
        if (lat)
            cmd(8'h06);
        frame({8'h02, addr[15:8], addr[7:0], d}, 1, v);
        check("array strobes", {15'h0, exp}, 16'(wr_count - n));
        if (exp)
        begin
            check("write address", {1'b0, addr[14:0]}, {1'b0, last_addr});
            check("write data", {8'h0, d}, {8'h0, last_data});
            check("write busy", 16'h0001, {15'h0, busy});
        end
        wait_idle();
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        rst        = 1'b1;
        wp_n       = 1'b1;
        watch      = 1'b0;
        oe_seen    = 1'b0;
        mismatches = 0;
        num_checks = 0;
        wr_count   = 0;
        tick(5);
        rst = 1'b0;
        tick(5);
        rd_status(8'h05, v);
        check("status after reset", 8'h00, v);
        watch = 1'b1;
        tick(10);
        frame({8'h15, 8'hff, 8'h00}, 1, v);
        watch = 1'b0;
        check("so drive on bad opcode", 16'h0000, {15'h0, oe_seen});
        for (int i = 0; i < 2; i++)
        begin
            cmd(i ? 8'h0e : 8'h06);
            rd_status(i ? 8'h0d : 8'h05, v);
            check("latch set", 8'h02, v);
            wp_n = i ? 1'b0 : 1'b1;
            cmd(i ? 8'h0c : 8'h04);
            rd_status(8'h05, v);
            check("latch clear", 8'h00, v);
        end
        wp_n = 1'b1;
        wr_array(16'h0010, 8'ha5, 0, 0);
        wr_array(16'h8010, 8'h5a, 1, 1);
        cmd(8'h06);
        frame({8'h09, 8'h00}, 1, v);
        cmd(8'h06);
        rd_status(8'h05, v);
        check("status while busy", 8'hff, v);
        wait_idle();
        rd_status(8'h05, v);
        check("latch after cycle", 8'h00, v);
        oe_seen = 1'b0;
        frame({8'h0b, 8'h12, 8'h34, 8'h00}, 0, v);
        check("read byte", 8'h6e, v);
        u_link_master.pause(3);
        check("so drive in hold", 16'h0000, {15'h0, oe_seen});
        u_link_master.xbyte(8'h00, v);
        u_link_master.frame_close();
        check("read after hold", 8'h6f, v);
        for (int c = 0; c < 4; c++)
        begin
            lo = (c == 3) ? 16'h0000 : 16'h8000 - 16'(c) * 16'h2000;
            wr_status(8'h01, {4'h0, 2'(c), 2'b00}, 1);
            rd_status(8'h05, v);
            check("block code", {4'h0, 2'(c), 2'b00}, v);
            if (c != 3)
                wr_array(lo - 16'h0001, 8'h3c, 1, 1);
            if (c != 0)
                wr_array(lo, 8'hc3, 1, 0);
        end
        wr_status(8'h01, 8'h84, 1);
        wp_n = 1'b0;
        wr_status(8'h01, 8'h00, 0);
        rd_status(8'h05, v);
        check("guard kept", 8'h84, v & 8'hfd);
        wr_array(16'h0100, 8'h77, 1, 1);
        wr_array(16'h7000, 8'h77, 1, 0);
        wp_n = 1'b1;
        wr_status(8'h01, 8'h00, 1);
        wp_n = 1'b0;
        wr_status(8'h01, 8'h88, 1);
        wp_n = 1'b1;
        cmd(8'h06);
        frame({8'h01, 8'h00}, 0, v);
        wp_n = 1'b0;
        u_link_master.tick(2);
        wp_n = 1'b1;
        u_link_master.frame_close();
        check("aborted status write", 16'h0000, {15'h0, busy});
        rd_status(8'h05, v);
        check("status after abort", 8'h88, v & 8'hfd);
        cmd(8'h06);
        frame({8'h01, 8'h00}, 1, v);
        wp_n = 1'b0;
        wait_idle();
        rd_status(8'h05, v);
        check("status write past start", 8'h00, v);
        wp_n = 1'b1;
        results();
    end
endmodule
